// ### test/ffp_fan_model.sv
// Purpose: cooling fan load that times the pwm high phase
// Assumes: pwm active high
// Notes:   hi_cyc is the length of the last finished high phase
`default_nettype none
module ffp_fan_model (
    input  wire logic        aclk,
    input  wire logic        pwm_out,
    output var  logic [15:0] hi_cyc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] run_r = 16'h0000;
    logic        pwm_q = 1'b0;
    initial hi_cyc = 16'h0000;
    always @(posedge aclk)
    begin
        pwm_q <= pwm_out;
        run_r <= pwm_out ? run_r + 16'h0001 : 16'h0000;
        if (pwm_q && !pwm_out)
            hi_cyc <= run_r;
    end
endmodule
`default_nettype wire

// ### test/ffp_fan_ramp_props.sv
// Purpose: port checks of the filtered fan pwm ramp
// Assumes: aw and w offered together by the master
// Notes:   pwm period is 240 slots of SLOT_CYC cycles
`include "ffp_fan_ramp_defs.vh"
`default_nettype none
module ffp_fan_ramp_props #(
    parameter int SLOT_CYC = 3
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        meas_req,
    input wire logic        pwm_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PER = 240 * SLOT_CYC;
    logic        pwm_q;
    logic        seen_r;
    logic [31:0] per_r;
    logic [31:0] hi_r;
    logic [7:0]  rda_r;
    logic        rise;
    logic        fall;
    assign rise = pwm_out && !pwm_q;
    assign fall = pwm_q && !pwm_out;
    // ----------------------------------------
    // pwm phase counters, last read address
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwm_q  <= 1'b0;
            seen_r <= 1'b0;
            per_r  <= 32'h0000_0000;
            hi_r   <= 32'h0000_0000;
            rda_r  <= 8'h00;
        end
        else
        begin
            pwm_q  <= pwm_out;
            seen_r <= seen_r | rise;
            per_r  <= rise ? 32'h0000_0001 : per_r + 32'h0000_0001;
            hi_r   <= rise ? 32'h0000_0001 : hi_r + 32'h0000_0001;
            if (s_axi_arvalid && s_axi_arready)
                rda_r <= s_axi_araddr;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_RST_IDLE: assert property ($rose(aresetn) |-> !pwm_out
        && !meas_req && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs busy after reset");
    AST_REQ_PULSE: assert property (meas_req |=> !meas_req)
        else $error("meas_req longer than one cycle");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    AST_B_ANS: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_ERR: assert property (s_axi_rvalid
        && s_axi_rresp == `FFP_RESP_SLVERR |-> s_axi_rdata == 0)
        else $error("error read carries data");
    AST_FILT_RD: assert property (
        s_axi_rvalid && s_axi_rresp == `FFP_RESP_OKAY
        && rda_r == {`FFP_IDX_FILTER, 2'b00}
        |-> s_axi_rdata[1] == 1'b0 && s_axi_rdata[31:8] == 0)
        else $error("filter read sets unused bits");
    AST_PERIOD: assert property (
        rise && seen_r |-> per_r % PER == 0)
        else $error("pwm period not 240 slots");
    AST_SLOT: assert property (
        fall |-> hi_r % SLOT_CYC == 0)
        else $error("pwm high time not whole slots");
endmodule
bind ffp_fan_ramp ffp_fan_ramp_props #(.SLOT_CYC(SLOT_CYC)) u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .meas_req(meas_req), .pwm_out(pwm_out));
`default_nettype wire

// ### test/ffp_fan_ramp_tb.sv
// Purpose: self-checking bench of the filtered fan pwm ramp
// Assumes: shortened slot, rate and spin-up counts
// Notes:   aw and w offered together, responses taken late
`include "ffp_fan_ramp_defs.vh"
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
    miscompares++; $display("Error %s exp %0h got %0h", n, e, g); end end
module ffp_fan_ramp_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = 3;
    localparam int UPD = 20;
    localparam int PER = 240 * SC;
    localparam int LIM = 3000;
    localparam logic [7:0] A_FILT = {`FFP_IDX_FILTER, 2'b00};
    localparam logic [7:0] A_CTRL = {`FFP_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_STAT = {`FFP_IDX_STAT, 2'b00};
    localparam logic [1:0] OK = `FFP_RESP_OKAY;
    localparam logic [1:0] ERR = `FFP_RESP_SLVERR;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        s_axi_awvalid = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [2:0]  s_axi_awprot = 3'h0;
    logic        s_axi_wvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [2:0]  s_axi_arprot = 3'h0;
    logic        s_axi_rready = 1'b0;
    logic        meas_done = 1'b0;
    logic [7:0]  new_duty = 8'h00;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, meas_req, pwm_out;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
    logic [31:0] s_axi_rdata, rd_d;
    logic [15:0] hi_cyc;
    int          miscompares = 0;
    int          n_tests = 0;
    ffp_fan_ramp #(.SLOT_CYC(SC), .UPD_FAST_CYC(UPD), .SPINUP_CYC(10))
    u_ffp_fan_ramp (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .meas_done, .new_duty, .meas_req, .pwm_out);
    ffp_fan_model u_ffp_fan_model (.aclk, .pwm_out, .hi_cyc);
    initial
    begin
        forever #12.5 aclk = ~aclk;
    end
    // ----------------------------------------
    // bus and loop helpers
    // ----------------------------------------
    task automatic print_verdict();
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tmo(input int i);
        if (i >= LIM)
        begin
            miscompares++;
            print_verdict();
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        int   i;
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (i = 0; (aw || w) && i < LIM; i++)
        begin
            @(posedge aclk);
            if (aw && s_axi_awready === 1'b1)
            begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1)
            begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        tmo(i);
        repeat (2) @(posedge aclk);
        s_axi_bready <= 1'b1;
        i = 0;
        do
        begin
            @(posedge aclk);
            i++;
        end while (s_axi_bvalid !== 1'b1 && i < LIM);
        tmo(i);
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (i = 0; i < LIM; i++)
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                break;
        end
        tmo(i);
        s_axi_arvalid <= 1'b0;
        repeat (2) @(posedge aclk);
        s_axi_rready <= 1'b1;
        i = 0;
        do
        begin
            @(posedge aclk);
            i++;
        end while (s_axi_rvalid !== 1'b1 && i < LIM);
        tmo(i);
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic meas(input logic [7:0] d);
        meas_done <= 1'b1;
        new_duty <= d;
        @(posedge aclk);
        meas_done <= 1'b0;
        axi_rd(A_STAT);
    endtask
    task automatic wpulse(output int n);
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end while (meas_req !== 1'b1 && n < LIM);
        tmo(n);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_regs();
        axi_rd(A_FILT);
        `CHK("filt_rst", 32'h0000_0010, rd_d)
        axi_rd(8'h00);
        `CHK("bad_rresp", ERR, rd_r)
        axi_wr(A_FILT, 32'h0000_00FF, OK);
        axi_rd(A_FILT);
        `CHK("filt_rw", 32'h0000_00FD, rd_d)
        axi_wr(8'h00, 32'h0000_00FF, ERR);
    endtask
    task automatic s_spin();
        axi_wr(A_FILT, 32'h0000_0010, OK);
        axi_wr(A_CTRL, 32'h0000_0001, OK);
        meas(8'h50);
        `CHK("direct", 8'h50, rd_d[7:0])
        `CHK("spin_on", 1'b1, rd_d[8])
        meas(8'h00);
        `CHK("direct0", 8'h00, rd_d[7:0])
        axi_wr(A_FILT, 32'h0000_0090, OK);
        meas(8'h50);
        `CHK("spin_off", 1'b0, rd_d[8])
        repeat (3 * PER) @(posedge aclk);
        `CHK("hi_cyc", 16'(80 * SC), hi_cyc)
    endtask
    task automatic s_ramp();
        int c;
        int s;
        for (c = 0; c < 4; c++)
        begin
            s = 1 << c;
            axi_wr(A_FILT, 32'h0000_0090, OK);
            meas(8'h64);
            axi_wr(A_FILT, 32'h0000_0091 | 32'(c << 5), OK);
            meas(8'hC8);
            `CHK("up1", 8'(8'h64 + s), rd_d[7:0])
            meas(8'hC8);
            `CHK("up2", 8'(8'h64 + 2 * s), rd_d[7:0])
            meas(8'h32);
            `CHK("down", 8'(8'h64 + s), rd_d[7:0])
            meas(8'(8'h64 + s));
            `CHK("equal", 8'(8'h64 + s), rd_d[7:0])
        end
        meas(8'h6E);
        `CHK("clamp", 8'h6E, rd_d[7:0])
        meas(8'h00);
        `CHK("down8", 8'h66, rd_d[7:0])
        axi_wr(A_FILT, 32'h0000_0090, OK);
        meas(8'hFF);
        `CHK("top", 8'hF0, rd_d[7:0])
    endtask
    task automatic s_rate();
        int c;
        int n;
        for (c = 0; c < 8; c++)
        begin
            axi_wr(A_FILT, 32'h0000_0080 | 32'(c << 2), OK);
            wpulse(n);
            wpulse(n);
            wpulse(n);
            `CHK("rate", UPD << (7 - c), n)
        end
    endtask
    task automatic s_man();
        axi_wr(A_CTRL, 32'h0000_A000, OK);
        axi_rd(A_CTRL);
        `CHK("ctrl_rd", 32'h0000_A000, rd_d)
        repeat (3 * PER) @(posedge aclk);
        `CHK("man_hi", 16'(160 * SC), hi_cyc)
    endtask
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        s_regs();
        s_spin();
        s_ramp();
        s_rate();
        s_man();
        print_verdict();
    end
endmodule
`undef CHK
`default_nettype wire

// ### verilog/ffp_fan_ramp.v
// Purpose: filtered-mode slew limiter for the automatic fan pwm loop
// Assumes: target duty and measurement strobe come from same-clock logic
// Notes:   registers over axi4-lite, filter register at index 0x23
//
// Added by the designer: the AXI4-Lite interface to the registers.
`include "ffp_fan_ramp_defs.vh"
`default_nettype none

module ffp_fan_ramp #(
    parameter SLOT_CYC     = `FFP_SLOT_CYC,
    parameter UPD_FAST_CYC = `FFP_UPD_FAST_CYC,
    parameter SPINUP_CYC   = `FFP_SPINUP_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [7:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    input  wire [7:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    input  wire        meas_done,
    input  wire [7:0]  new_duty,
    output reg         meas_req,
    output wire        pwm_out
);

    // -----------------------------------------------------------------
    // register state
    // -----------------------------------------------------------------
    reg  [7:0]  filt_r;
    reg         auto_en_r;
    reg  [7:0]  man_duty_r;
    reg  [7:0]  held_r;
    reg         spinning_r;
    reg  [31:0] spin_cnt_r;
    reg  [31:0] upd_cnt_r;
    reg  [7:0]  drive_r;

    wire        spin_dis = filt_r[`FFP_FB_SPIN_DIS];
    wire [1:0]  ramp_code = filt_r[`FFP_FB_RAMP_HI:`FFP_FB_RAMP_LO];
    wire [2:0]  rate_code = filt_r[`FFP_FB_RATE_HI:`FFP_FB_RATE_LO];
    wire        filt_en = filt_r[`FFP_FB_FILT_EN];

    // -----------------------------------------------------------------
    // write channel
    // -----------------------------------------------------------------
    reg         aw_got_r;
    reg  [5:0]  aw_idx_r;
    reg         w_got_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;
    reg         aw_got_nxt;
    reg         w_got_nxt;
    reg         bvalid_nxt;
    wire        aw_hs = s_axi_awvalid && s_axi_awready;
    wire        w_hs = s_axi_wvalid && s_axi_wready;
    wire        do_wr = aw_got_r && w_got_r && !s_axi_bvalid;
    wire        wr_filt = (aw_idx_r == `FFP_IDX_FILTER);
    wire        wr_ctrl = (aw_idx_r == `FFP_IDX_CTRL);
    wire        wr_stat = (aw_idx_r == `FFP_IDX_STAT);
    wire        wr_hit = wr_filt || wr_ctrl || wr_stat;

    always @*
    begin
        aw_got_nxt = aw_got_r;
        w_got_nxt  = w_got_r;
        bvalid_nxt = s_axi_bvalid;
        if (aw_hs)
            aw_got_nxt = 1'b1;
        if (w_hs)
            w_got_nxt = 1'b1;
        if (do_wr)
        begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
        end
        else if (s_axi_bvalid && s_axi_bready)
            bvalid_nxt = 1'b0;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r      <= 1'b0;
            aw_idx_r      <= 6'h00;
            w_got_r       <= 1'b0;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `FFP_RESP_OKAY;
        end
        else
        begin
            aw_got_r      <= aw_got_nxt;
            w_got_r       <= w_got_nxt;
            s_axi_bvalid  <= bvalid_nxt;
            s_axi_awready <= !aw_got_nxt && !bvalid_nxt;
            s_axi_wready  <= !w_got_nxt && !bvalid_nxt;
            if (aw_hs)
                aw_idx_r <= s_axi_awaddr[7:2];
            if (w_hs)
            begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_wr)
                s_axi_bresp <= wr_hit ? `FFP_RESP_OKAY : `FFP_RESP_SLVERR;
        end
    end

    // -----------------------------------------------------------------
    // software registers
    // -----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            filt_r     <= `FFP_FILT_RST;
            auto_en_r  <= 1'b0;
            man_duty_r <= 8'h00;
        end
        else if (do_wr)
        begin
            if (wr_filt && w_strb_r[0])
                filt_r <= w_data_r[7:0] & `FFP_FILT_WMASK;
            if (wr_ctrl && w_strb_r[0])
                auto_en_r <= w_data_r[`FFP_CB_AUTO_EN];
            if (wr_ctrl && w_strb_r[1])
                man_duty_r <= w_data_r[`FFP_CB_MAN_HI:`FFP_CB_MAN_LO];
        end
    end

    // -----------------------------------------------------------------
    // read channel
    // -----------------------------------------------------------------
    reg  [31:0] rd_mux;
    reg  [1:0]  rd_resp;
    wire [5:0]  ar_idx = s_axi_araddr[7:2];
    wire        ar_hs = s_axi_arvalid && s_axi_arready;

    always @*
    begin
        rd_mux  = 32'h0000_0000;
        rd_resp = `FFP_RESP_OKAY;
        case (ar_idx)
            `FFP_IDX_FILTER:
                rd_mux[7:0] = filt_r;
            `FFP_IDX_CTRL:
            begin
                rd_mux[`FFP_CB_AUTO_EN] = auto_en_r;
                rd_mux[`FFP_CB_MAN_HI:`FFP_CB_MAN_LO] = man_duty_r;
            end
            `FFP_IDX_STAT:
            begin
                rd_mux[7:0] = held_r;
                rd_mux[`FFP_SB_SPINNING] = spinning_r;
                rd_mux[`FFP_SB_AUTO] = auto_en_r;
            end
            default:
                rd_resp = `FFP_RESP_SLVERR;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `FFP_RESP_OKAY;
        end
        else
        begin
            if (ar_hs)
            begin
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= rd_resp;
                s_axi_arready <= 1'b0;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
            else
                s_axi_arready <= !s_axi_rvalid;
        end
    end

    // -----------------------------------------------------------------
    // measurement cadence
    // -----------------------------------------------------------------
    // fastest code gives 8 updates/s, each lower code halves the rate
    wire [2:0]  rate_shift = `FFP_RATE_MAX - rate_code;
    wire [31:0] upd_period = UPD_FAST_CYC[31:0] << rate_shift;
    wire        upd_end = (upd_cnt_r >= upd_period - 32'h0000_0001);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            upd_cnt_r <= 32'h0000_0000;
            meas_req  <= 1'b0;
        end
        else if (!auto_en_r)
        begin
            upd_cnt_r <= 32'h0000_0000;
            meas_req  <= 1'b0;
        end
        else
        begin
            upd_cnt_r <= upd_end ? 32'h0000_0000 : upd_cnt_r + 32'h0000_0001;
            meas_req  <= upd_end;
        end
    end

    // -----------------------------------------------------------------
    // ramp step
    // -----------------------------------------------------------------
    reg  [7:0]  step;
    reg  [7:0]  held_nxt;
    reg  [7:0]  tgt;
    reg  [7:0]  diff;

    always @*
    begin
        case (ramp_code)
            2'h0:    step = 8'h01;
            2'h1:    step = 8'h02;
            2'h2:    step = 8'h04;
            2'h3:    step = 8'h08;
            default: step = 8'h01;
        endcase
        // targets beyond a full period are treated as full on
        tgt  = (new_duty > `FFP_SLOTS_W) ? `FFP_SLOTS_W : new_duty;
        diff = 8'h00;
        held_nxt = held_r;
        if (!filt_en)
            held_nxt = tgt;
        else if (tgt > held_r)
        begin
            diff = tgt - held_r;
            held_nxt = held_r + ((diff < step) ? diff : step);
        end
        else if (tgt < held_r)
        begin
            diff = held_r - tgt;
            held_nxt = held_r - ((diff < step) ? diff : step);
        end
    end

    // -----------------------------------------------------------------
    // held duty and spin-up
    // -----------------------------------------------------------------
    wire        take = auto_en_r && meas_done;
    wire        start_fan = take && (held_r == 8'h00) && (held_nxt != 8'h00);
    wire [7:0]  man_clip = (man_duty_r > `FFP_SLOTS_W) ? `FFP_SLOTS_W
                                                        : man_duty_r;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            held_r     <= 8'h00;
            spinning_r <= 1'b0;
            spin_cnt_r <= 32'h0000_0000;
        end
        else
        begin
            if (take)
                held_r <= held_nxt;
            if (start_fan && !spin_dis)
            begin
                spinning_r <= 1'b1;
                spin_cnt_r <= SPINUP_CYC[31:0] - 32'h0000_0001;
            end
            else if (spinning_r)
            begin
                // a stop request or disabled spin-up ends the kick early
                if (spin_cnt_r == 32'h0000_0000 || spin_dis || !auto_en_r
                    || (take && held_nxt == 8'h00))
                    spinning_r <= 1'b0;
                spin_cnt_r <= spin_cnt_r - 32'h0000_0001;
            end
        end
    end

    // -----------------------------------------------------------------
    // pwm drive
    // -----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
            drive_r <= 8'h00;
        else if (!auto_en_r)
            drive_r <= man_clip;
        else if (spinning_r)
            drive_r <= `FFP_SLOTS_W;
        else
            drive_r <= held_r;
    end

    ffp_pwm_gen #(
        .SLOT_CYC (SLOT_CYC)
    ) u_pwm (
        .aclk    (aclk),
        .aresetn (aresetn),
        .duty    (drive_r),
        .pwm_out (pwm_out)
    );

endmodule

`default_nettype wire

// ### verilog/ffp_fan_ramp_defs.vh
// Purpose: constants of the filtered fan pwm ramp block
// Assumes: 40 MHz aclk, byte address of a register is four times its index
// Notes:   Function
// Function
// - each pwm period is split into 240 equal slots, the smallest step
// - a 33 percent setting gives 80 slots high and 160 slots low
// - filter bits 6:5 pick step 1, 2, 4 or 8 slots
// - filtered mode raises held duty by step when new duty is higher
// - filtered mode lowers held duty by step when new duty is lower
// - adjusted duty is stored, used for next compare and drives pwm
// - one compare and adjustment per completed temperature measurement
// - filter bits 4:2 select adc sample rate, reset code 100
// - update rates 0.0625 to 8 per second, ascending with the code
// - filter bit 7 set suppresses fan spin-up, resets to 0
// - filtering applies only while filter bit 0 is 1, resets to 0
// - with filtering off each new duty goes straight to the output
`ifndef FFP_FAN_RAMP_DEFS_VH
`define FFP_FAN_RAMP_DEFS_VH

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define FFP_CLK_MHZ          40
`define FFP_PWM_PERIOD_US    32000
`define FFP_SLOTS            240
`define FFP_SLOTS_W          8'hF0
`define FFP_SLOT_CYC         ((`FFP_PWM_PERIOD_US * `FFP_CLK_MHZ) / `FFP_SLOTS)
`define FFP_UPD_FAST_MS      125
`define FFP_UPD_FAST_CYC     (`FFP_UPD_FAST_MS * 1000 * `FFP_CLK_MHZ)
`define FFP_SPINUP_MS        2000
`define FFP_SPINUP_CYC       (`FFP_SPINUP_MS * 1000 * `FFP_CLK_MHZ)
`define FFP_RATE_MAX         3'h7

// ---------------------------------------------------------------------
// register indexes (byte address = index * 4)
// ---------------------------------------------------------------------
`define FFP_IDX_FILTER       6'h23
`define FFP_IDX_CTRL         6'h28
`define FFP_IDX_STAT         6'h29

// ---------------------------------------------------------------------
// filter register fields and reset
// ---------------------------------------------------------------------
`define FFP_FILT_RST         8'h10
`define FFP_FILT_WMASK       8'hFD
`define FFP_FB_SPIN_DIS      7
`define FFP_FB_RAMP_HI       6
`define FFP_FB_RAMP_LO       5
`define FFP_FB_RATE_HI       4
`define FFP_FB_RATE_LO       2
`define FFP_FB_FILT_EN       0

// ---------------------------------------------------------------------
// control and status fields
// ---------------------------------------------------------------------
`define FFP_CB_AUTO_EN       0
`define FFP_CB_MAN_HI        15
`define FFP_CB_MAN_LO        8
`define FFP_SB_SPINNING      8
`define FFP_SB_AUTO          9

// ---------------------------------------------------------------------
// bus answers
// ---------------------------------------------------------------------
`define FFP_RESP_OKAY        2'h0
`define FFP_RESP_SLVERR      2'h2

`endif

// ### verilog/ffp_pwm_gen.v
// Purpose: pwm waveform with a period of 240 equal slots
// Assumes: duty in slots, 0 to 240, sampled at each period start
// Notes:   output is registered
`include "ffp_fan_ramp_defs.vh"
`default_nettype none

module ffp_pwm_gen #(
    parameter SLOT_CYC = `FFP_SLOT_CYC
) (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire [7:0] duty,
    output reg        pwm_out
);

    // -----------------------------------------------------------------
    // slot timing
    // -----------------------------------------------------------------
    reg [15:0] cyc_r;
    reg [7:0]  slot_r;
    reg [7:0]  duty_r;
    wire       slot_end = (cyc_r == SLOT_CYC[15:0] - 16'h0001);
    wire       per_end  = slot_end && (slot_r == `FFP_SLOTS_W - 8'h01);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cyc_r   <= 16'h0000;
            slot_r  <= 8'h00;
            duty_r  <= 8'h00;
            pwm_out <= 1'b0;
        end
        else
        begin
            cyc_r <= slot_end ? 16'h0000 : cyc_r + 16'h0001;
            if (per_end)
            begin
                slot_r <= 8'h00;
                // new duty only at a period edge, no runt pulses
                duty_r <= duty;
            end
            else if (slot_end)
                slot_r <= slot_r + 8'h01;
            // high for duty slots, low for the rest, e.g. 80 and 160
            pwm_out <= (slot_r < duty_r);
        end
    end

endmodule

`default_nettype wire

// ### verilog/unused_placeholder_none.v
`default_nettype none
`default_nettype wire
